// ===== hw/lcdos_map.vh
// Register offsets, field positions and reset values of the LCD output stage
`ifndef LCDOS_MAP_VH
`define LCDOS_MAP_VH

`define LCDOS_ADDR_W        8
`define LCDOS_OFF_PANEL_CFG 8'h00
`define LCDOS_OFF_POWER     8'h04
`define LCDOS_OFF_CON_CTRL  8'h08
`define LCDOS_OFF_CON_CMP   8'h0C
`define LCDOS_OFF_IRQ_EN    8'h10
`define LCDOS_OFF_IRQ_DIS   8'h14
`define LCDOS_OFF_IRQ_CLR   8'h18
`define LCDOS_OFF_IRQ_MASK  8'h1C
`define LCDOS_OFF_IRQ_STAT  8'h20
`define LCDOS_OFF_MODE      8'h24

`define LCDOS_POL_LSB       8
`define LCDOS_POL_MSB       12
`define LCDOS_EDGE_BIT      13
`define LCDOS_PWR_BIT       0
`define LCDOS_GUARD_LSB     1
`define LCDOS_GUARD_MSB     7
`define LCDOS_BUSY_BIT      31
`define LCDOS_PS_LSB        0
`define LCDOS_PS_MSB        1
`define LCDOS_CPOL_BIT      2
`define LCDOS_CEN_BIT       3

`define LCDOS_MODE_STN4S    3'h0
`define LCDOS_MODE_STN8S    3'h1
`define LCDOS_MODE_STN8D    3'h2
`define LCDOS_MODE_STN16D   3'h3
`define LCDOS_MODE_TFT24    3'h4
`define LCDOS_MODE_TFT16    3'h5

`define LCDOS_NIRQ          6
`define LCDOS_RST_PANEL_CFG 32'h0000_0000
`define LCDOS_RST_POWER     32'h0000_000E
`define LCDOS_RST_CON_CTRL  32'h0000_0000
`define LCDOS_RST_CON_CMP   32'h0000_0000

`endif

// ===== hw/lcdos_top.v
// LCD output stage: polarity, power sequencing, contrast PWM, data mux, interrupts
`timescale 1ns/1ps
`include "lcdos_map.vh"
// Overview of operation
// - Bits 12:8 of the panel configuration register invert the power pin and, while powered, each other clock/control output.
// - Panel power follows the request bit only after guard-field frames elapse.
// - Contrast output is an 8-bit PWM from free counter versus compare value.
// - Counter below compare gives the active level, otherwise its inverse.
// - Pulse width spans zero to 255 counts in a 256-count period.
// - Prescale field picks one of four counter rates.
// - 4-bit single STN drives lines 3:0 only.
// - 8-bit single STN drives lines 7:0 only.
// - 8-bit dual STN: upper panel on 3:0, lower panel on 7:4.
// - 16-bit dual STN: upper panel on 7:0, lower panel on 15:8.
// - Mono STN shifts one bit per pixel, colour STN three consecutive bits.
// - 24-bit TFT: blue 23:16, green 15:8, red 7:0.
// - 16-bit TFT: blue 23:19, green 15:10, red 7:3.
// - Six interrupt sources, all on the core clock.
// - Memory error interrupt on DMA bus error response.
// - Underflow interrupt when serializer reads an empty FIFO.
// - Overwrite interrupt when DMA writes a full FIFO.
// - End-of-frame interrupt when DMA reloads frame base pointers.
// - End-of-line interrupt at line blanking with DMA inactive.
// - End-of-last-line interrupt at last line blanking with DMA inactive.
// - Enable, disable, clear registers per source; mask and status readable.
// - Data changes on pixel clock falling edge by default, rising edge selectable.
module lcdos_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        clk_en,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        pixel_clock_raw,
  input  wire        hsync_raw,
  input  wire        vsync_raw,
  input  wire        data_enable_raw,
  input  wire        pixel_valid,
  input  wire [23:0] pixel_data,
  input  wire        frame_start,
  input  wire        dma_bus_error,
  input  wire        fifo_read_empty,
  input  wire        fifo_write_full,
  input  wire        dma_base_reload,
  input  wire        line_blank_period,
  input  wire        last_line,
  input  wire        dma_active,
  output reg         pixel_clock,
  output reg         hsync,
  output reg         vsync,
  output reg         data_enable,
  output reg         panel_power_pin,
  output reg  [23:0] panel_data_bus,
  output reg         contrast_pwm_out,
  output reg         panel_power,
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus
  reg  [31:0] panel_config_reg;
  reg  [31:0] power_control_reg;
  reg  [31:0] contrast_control;
  reg  [7:0]  contrast_compare;
  reg  [2:0]  mode_reg;
  reg  [5:0]  irq_mask;
  reg  [5:0]  irq_status;
  reg  [7:0]  wr_addr;
  reg         aw_held;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;
  reg         w_held;
  reg         power_busy;

  wire        wr_go = aw_held & w_held & ~s_axi_bvalid;

  function mapped;
    input [7:0] a;
    begin
      case (a)
        `LCDOS_OFF_PANEL_CFG, `LCDOS_OFF_POWER, `LCDOS_OFF_CON_CTRL,
        `LCDOS_OFF_CON_CMP, `LCDOS_OFF_IRQ_EN, `LCDOS_OFF_IRQ_DIS,
        `LCDOS_OFF_IRQ_CLR, `LCDOS_OFF_IRQ_MASK, `LCDOS_OFF_IRQ_STAT,
        `LCDOS_OFF_MODE: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = s[k] ? d[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  wire wr_hit_en  = wr_go & (wr_addr == `LCDOS_OFF_IRQ_EN);
  wire wr_hit_dis = wr_go & (wr_addr == `LCDOS_OFF_IRQ_DIS);
  wire wr_hit_clr = wr_go & (wr_addr == `LCDOS_OFF_IRQ_CLR);
  wire wr_hit_pwr = wr_go & (wr_addr == `LCDOS_OFF_POWER);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready     <= 1'b0;
      s_axi_wready      <= 1'b0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= 2'h0;
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      wr_addr           <= 8'h00;
      wr_data           <= 32'h0000_0000;
      wr_strb           <= 4'h0;
      panel_config_reg  <= `LCDOS_RST_PANEL_CFG;
      power_control_reg <= `LCDOS_RST_POWER;
      contrast_control  <= `LCDOS_RST_CON_CTRL;
      contrast_compare  <= 8'h00;
      mode_reg          <= `LCDOS_MODE_STN4S;
      irq_mask          <= 6'h00;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_addr) ? 2'h0 : 2'h2;
        case (wr_addr)
          `LCDOS_OFF_PANEL_CFG: panel_config_reg <= merge(panel_config_reg, wr_data, wr_strb);
          `LCDOS_OFF_POWER:     power_control_reg <= merge(power_control_reg, wr_data, wr_strb);
          `LCDOS_OFF_CON_CTRL:  contrast_control <= merge(contrast_control, wr_data, wr_strb);
          `LCDOS_OFF_CON_CMP:   if (wr_strb[0]) contrast_compare <= wr_data[7:0];
          `LCDOS_OFF_MODE:      if (wr_strb[0]) mode_reg <= wr_data[2:0];
          default: ;
        endcase
        if (wr_hit_en & wr_strb[0])
          irq_mask <= irq_mask | wr_data[5:0];
        if (wr_hit_dis & wr_strb[0])
          irq_mask <= irq_mask & ~wr_data[5:0];
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (clk_en) begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped({s_axi_araddr[7:2], 2'h0}) ? 2'h0 : 2'h2;
        case ({s_axi_araddr[7:2], 2'h0})
          `LCDOS_OFF_PANEL_CFG: s_axi_rdata <= panel_config_reg;
          `LCDOS_OFF_POWER:     s_axi_rdata <= {power_busy, power_control_reg[30:0]};
          `LCDOS_OFF_CON_CTRL:  s_axi_rdata <= contrast_control;
          `LCDOS_OFF_CON_CMP:   s_axi_rdata <= {24'h000000, contrast_compare};
          `LCDOS_OFF_IRQ_MASK:  s_axi_rdata <= {26'h0, irq_mask};
          `LCDOS_OFF_IRQ_STAT:  s_axi_rdata <= {26'h0, irq_status};
          `LCDOS_OFF_MODE:      s_axi_rdata <= {29'h0, mode_reg};
          default:              s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Panel control synchronisers and polarity
  reg [3:0] sync_a;
  reg [3:0] sync_b;
  reg [3:0] sync_c;
  reg [3:0] ctl_level;
  wire [3:0] ctl_raw = {data_enable_raw, vsync_raw, hsync_raw, pixel_clock_raw};
  wire [4:0] contrast_active_level = panel_config_reg[`LCDOS_POL_MSB:`LCDOS_POL_LSB];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sync
      // A change is only accepted once the second and third stages agree
      always @(posedge aclk) begin
        if (!aresetn) begin
          sync_a[g]    <= 1'b0;
          sync_b[g]    <= 1'b0;
          sync_c[g]    <= 1'b0;
          ctl_level[g] <= 1'b0;
        end else if (clk_en) begin
          sync_a[g] <= ctl_raw[g];
          sync_b[g] <= sync_a[g];
          sync_c[g] <= sync_b[g];
          if (sync_b[g] == sync_c[g])
            ctl_level[g] <= sync_c[g];
        end
      end
    end
  endgenerate

  reg pclk_prev;
  wire launch_edge = panel_config_reg[`LCDOS_EDGE_BIT] ?
                     (ctl_level[0] & ~pclk_prev) : (~ctl_level[0] & pclk_prev);

  always @(posedge aclk) begin
    if (!aresetn) begin
      pixel_clock     <= 1'b0;
      hsync           <= 1'b0;
      vsync           <= 1'b0;
      data_enable     <= 1'b0;
      panel_power_pin <= 1'b0;
      pclk_prev       <= 1'b0;
    end else if (clk_en) begin
      pclk_prev <= ctl_level[0];
      // Clock/control outputs other than panel_power_pin are held low while the panel is unpowered, whatever their polarity bits
      pixel_clock     <= panel_power & (ctl_level[0] ^ contrast_active_level[0]);
      hsync           <= panel_power & (ctl_level[1] ^ contrast_active_level[1]);
      vsync           <= panel_power & (ctl_level[2] ^ contrast_active_level[2]);
      data_enable     <= panel_power & (ctl_level[3] ^ contrast_active_level[3]);
      panel_power_pin <= panel_power ^ contrast_active_level[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power sequencing: guard counted in frames after each request change
  reg [6:0] guard_cnt;
  wire      pwr_req = power_control_reg[`LCDOS_PWR_BIT];
  wire [6:0] guard  = power_control_reg[`LCDOS_GUARD_MSB:`LCDOS_GUARD_LSB];

  always @(posedge aclk) begin
    if (!aresetn) begin
      panel_power <= 1'b0;
      power_busy  <= 1'b0;
      guard_cnt   <= 7'h00;
    end else if (clk_en) begin
      if (wr_hit_pwr) begin
        guard_cnt  <= 7'h00;
        power_busy <= 1'b1;
      end else if (power_busy & (pwr_req == panel_power)) begin
        power_busy <= 1'b0;
      end else if (power_busy & frame_start) begin
        // A guard of zero is treated as one frame to keep the FIFOs primed
        if (guard_cnt + 7'h01 >= guard) begin
          panel_power <= pwr_req;
          power_busy  <= 1'b0;
        end else begin
          guard_cnt <= guard_cnt + 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Contrast PWM
  reg [7:0] pre_cnt;
  reg [7:0] con_cnt;
  wire [1:0] ps = contrast_control[`LCDOS_PS_MSB:`LCDOS_PS_LSB];
  wire tick = (ps == 2'h0) ? 1'b1 :
              (ps == 2'h1) ? (pre_cnt[0] == 1'b1) :
              (ps == 2'h2) ? (pre_cnt[1:0] == 2'h3) :
                             (pre_cnt[7:0] == 8'hFF);

  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt          <= 8'h00;
      con_cnt          <= 8'h00;
      contrast_pwm_out <= 1'b0;
    end else if (clk_en) begin
      pre_cnt <= pre_cnt + 8'h01;
      if (tick)
        con_cnt <= con_cnt + 8'h01; // wraps naturally at 8 bits
      if (!contrast_control[`LCDOS_CEN_BIT])
        contrast_pwm_out <= ~contrast_control[`LCDOS_CPOL_BIT];
      else if (con_cnt < contrast_compare)
        contrast_pwm_out <= contrast_control[`LCDOS_CPOL_BIT];
      else
        contrast_pwm_out <= ~contrast_control[`LCDOS_CPOL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data mux; pixel_data holds serializer bits already packed, RGB consecutive
  reg [23:0] next_data;
  always @* begin
    next_data = 24'h000000;
    case (mode_reg)
      `LCDOS_MODE_STN4S:  next_data = {20'h00000, pixel_data[3:0]};
      `LCDOS_MODE_STN8S:  next_data = {16'h0000, pixel_data[7:0]};
      `LCDOS_MODE_STN8D:  next_data = {16'h0000, pixel_data[7:4], pixel_data[3:0]};
      `LCDOS_MODE_STN16D: next_data = {8'h00, pixel_data[15:8], pixel_data[7:0]};
      `LCDOS_MODE_TFT24:  next_data = pixel_data;
      `LCDOS_MODE_TFT16:  next_data = {pixel_data[23:19], 3'h0, pixel_data[15:10], 2'h0,
                                       pixel_data[7:3], 3'h0};
      default:            next_data = 24'h000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn)
      panel_data_bus <= 24'h000000;
    else if (clk_en) begin
      if (!panel_power)
        panel_data_bus <= 24'h000000;
      else if (pixel_valid & launch_edge)
        panel_data_bus <= next_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts, all on aclk; set wins over clear
  wire [5:0] irq_event = {line_blank_period & last_line & ~dma_active,
                          line_blank_period & ~dma_active,
                          dma_base_reload,
                          fifo_write_full,
                          fifo_read_empty,
                          dma_bus_error};
  wire [5:0] clr_bits = (wr_hit_clr & wr_strb[0]) ? wr_data[5:0] : 6'h00;

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 6'h00;
      irq        <= 1'b0;
    end else if (clk_en) begin
      irq_status <= (irq_status & ~clr_bits) | irq_event;
      irq        <= |(irq_status & irq_mask);
    end
  end

endmodule // lcdos_top

// ===== tb/lcdos_out_monitor.sv
// Port-level assertions for the LCD output stage
`timescale 1ns/1ps
module lcdos_out_monitor (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        frame_start,
  input wire        dma_bus_error,
  input wire        fifo_read_empty,
  input wire        fifo_write_full,
  input wire        dma_base_reload,
  input wire        line_blank_period,
  input wire        pixel_clock,
  input wire        hsync,
  input wire        vsync,
  input wire        data_enable,
  input wire        panel_power,
  input wire        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A register write may unmask a pending source, so it counts as a cause
  wire ev = dma_bus_error | fifo_read_empty | fifo_write_full | dma_base_reload
          | line_blank_period | s_axi_wvalid;
  ////////////////////////////////////////////////////////////////
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  a_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_power_frames: assert property ($changed(panel_power) |-> $past(frame_start) ||
      $past(frame_start, 2) || $past(frame_start, 3))
    else $error("panel power moved off a frame boundary");
  a_dark_unpowered: assert property (!panel_power && !$past(panel_power) |->
      !(hsync | vsync | data_enable | pixel_clock))
    else $error("panel signals active while unpowered");
  a_irq_cause: assert property ($rose(irq) |-> $past(ev) || $past(ev, 2) ||
      $past(ev, 3) || $past(ev, 4))
    else $error("irq rose without a cause");
  c_power_on: cover property ($rose(panel_power));
  c_irq_up: cover property ($rose(irq));
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule // lcdos_out_monitor

// ===== tb/lcdos_panel_model.sv
// Panel model: latches the data bus on its sampling edge
`timescale 1ns/1ps
module lcdos_panel_model (
  input  wire         pixel_clock,
  input  wire         panel_power,
  input  wire  [23:0] panel_data_bus,
  output logic [23:0] word
);
  initial word = 24'h000000;
  // Device launches on the falling edge by default, so the panel takes the rising one
  always @(posedge pixel_clock) begin
    if (panel_power) begin
      word <= panel_data_bus;
    end
  end
endmodule // lcdos_panel_model

// ===== tb/tb.sv
// Self-checking bench for the LCD output stage
`timescale 1ns/1ps
module tb;
  logic        aclk = 0, aresetn = 0, clk_en = 1, pclk_run = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, pixel_valid = 0, frame_start = 0;
  logic        pixel_clock_raw = 0, hsync_raw = 0, vsync_raw = 0, data_enable_raw = 0;
  logic [23:0] pixel_data = 0;
  logic        dma_bus_error = 0, fifo_read_empty = 0, fifo_write_full = 0;
  logic        dma_base_reload = 0, line_blank_period = 0, last_line = 0, dma_active = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         pixel_clock, hsync, vsync, data_enable, panel_power_pin;
  wire         contrast_pwm_out, panel_power, irq;
  wire  [23:0] panel_data_bus, word;
  int          n_errors = 0, n_tests = 0;
  logic [1:0]  bresp_seen = 2'h0;
  localparam logic [23:0] MUX_IN [6] = '{24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF,
                                         24'hFFFFFF, 24'h123456, 24'hFFFFFF};
  localparam logic [23:0] MUX_EXP [6] = '{24'h00000F, 24'h0000FF, 24'h0000FF,
                                          24'h00FFFF, 24'h123456, 24'hF8FCF8};
  localparam int CT [6][4] = '{'{8'h0C, 8'h40, 256, 64}, '{8'h0D, 8'h40, 512, 128},
    '{8'h0E, 8'h40, 1024, 256}, '{8'h08, 8'h40, 256, 192}, '{8'h0C, 8'h00, 256, 0},
    '{8'h0C, 8'hFF, 256, 255}};
  localparam logic [5:0] IRQ_EXP [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h30, 6'h00};

  lcdos_top dut (.*);
  lcdos_panel_model panel (.pixel_clock(pixel_clock), .panel_power(panel_power),
                           .panel_data_bus(panel_data_bus), .word(word));
  ////////////////////////////////////////////////////////////////
  initial forever #5 aclk = ~aclk;
  // Raw pixel clock from the timing generator, eight core cycles a period
  always begin
    repeat (4) @(posedge aclk);
    if (pclk_run) pixel_clock_raw <= ~pixel_clock_raw;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(nm, e, d);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rdchk("power reset", 8'h04, 32'h0000000E);
    rdchk("panel cfg reset", 8'h00, 32'h0);
    rdchk("contrast ctrl reset", 8'h08, 32'h0);
    rdchk("compare reset", 8'h0C, 32'h0);
    rdchk("enable reads zero", 8'h10, 32'h0);
    axr(8'h80, d, r);
    chk("unmapped resp", 32'h2, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    axw(8'h80, 32'h0);
    chk("unmapped write resp", 32'h2, {30'h0, bresp_seen});
  endtask

  task automatic frame();
    @(posedge aclk);
    frame_start <= 1;
    @(posedge aclk);
    frame_start <= 0;
    repeat (6) @(posedge aclk);
  endtask

  task automatic t_power();
    axw(8'h04, 32'h05); // Guard of two frames, never zero
    frame();
    chk("power after one frame", 32'h0, panel_power);
    frame();
    chk("power after guard", 32'h1, panel_power);
  endtask

  task automatic pins(input logic [31:0] cfg, input logic [3:0] raw, input logic [4:0] e);
    axw(8'h00, cfg);
    @(posedge aclk);
    {pixel_clock_raw, hsync_raw, vsync_raw, data_enable_raw} <= raw;
    repeat (8) @(posedge aclk);
    chk("panel pins", e, {pixel_clock, hsync, vsync, data_enable, panel_power_pin});
  endtask

  task automatic t_polarity();
    pins(32'h1F00, 4'h0, 5'h1E);
    pins(32'h1F00, 4'hF, 5'h00);
    pins(32'h0000, 4'hF, 5'h1F);
    pins(32'h0000, 4'h0, 5'h01);
  endtask

  task automatic t_mux();
    pixel_valid <= 1;
    pclk_run <= 1;
    for (int i = 0; i < 6; i++) begin
      pixel_data <= MUX_IN[i];
      axw(8'h24, i);
      repeat (48) @(posedge aclk);
      chk("panel data", MUX_EXP[i], word);
    end
    axw(8'h24, 4);
    launch(32'h0000, 24'h0F0F0F, 1'b0);
    launch(32'h2000, 24'hF0F0F0, 1'b1);
    pclk_run <= 0;
    pixel_valid <= 0;
  endtask

  // Data must change together with the selected pixel clock edge
  task automatic launch(input logic [31:0] cfg, input logic [23:0] d, input logic e);
    axw(8'h00, cfg);
    pixel_data <= d;
    for (int k = 0; k < 40 && panel_data_bus !== d; k++) @(posedge aclk);
    chk("launch data", d, panel_data_bus);
    chk("launch clock level", e, pixel_clock);
  endtask

  task automatic t_contrast();
    int n;
    for (int i = 0; i < 6; i++) begin
      axw(8'h0C, CT[i][1]);
      axw(8'h08, CT[i][0]);
      repeat (8) @(posedge aclk);
      n = 0;
      repeat (CT[i][2]) begin
        @(posedge aclk);
        if (contrast_pwm_out === 1'b1) n++;
      end
      chk("contrast high count", CT[i][3], n);
    end
  endtask

  task automatic pulse(input int i);
    @(posedge aclk);
    dma_bus_error <= (i == 0);
    fifo_read_empty <= (i == 1);
    fifo_write_full <= (i == 2);
    dma_base_reload <= (i == 3);
    line_blank_period <= (i > 3);
    last_line <= (i == 5);
    dma_active <= (i == 6);
    @(posedge aclk);
    {dma_bus_error, fifo_read_empty, fifo_write_full, dma_base_reload} <= 4'h0;
    line_blank_period <= 0;
    dma_active <= 0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic t_irq();
    axw(8'h10, 32'h3F);
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      rdchk("irq status", 8'h20, IRQ_EXP[i]);
      chk("irq line", IRQ_EXP[i] != 0, irq);
      axw(8'h18, 32'h3F);
      rdchk("status cleared", 8'h20, 32'h0);
    end
    rdchk("mask all", 8'h1C, 32'h3F);
    axw(8'h14, 32'h01);
    rdchk("mask less one", 8'h1C, 32'h3E);
    pulse(0);
    chk("masked irq", 32'h0, irq);
    rdchk("masked status", 8'h20, 32'h01);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    chk("reset outputs", 32'h0, {panel_power, irq, panel_data_bus});
    t_regs();
    t_power();
    t_polarity();
    t_mux();
    t_contrast();
    t_irq();
    conclude();
  end
endmodule // tb

bind lcdos_top lcdos_out_monitor mon (.*);
